// ==== verilog/srbr_pkg.sv ====
// Shared constants and carrier types for the SCSI residue byte recovery block.
// Assumes one 40 MHz core clock and that every user of these names writes srbr_pkg::name.
package srbr_pkg;

  // ********************************************************************
  // Widths and reset values
  // ********************************************************************
  localparam int OFFSET_W = 10;                    // Extended FIFO offset counter width
  localparam int COUNT_W = 24;                     // Byte counter width
  localparam int PTR_W = 32;                       // Instruction pointer width
  localparam int SFIFO_W = 5;                      // Valid-byte count of the receive FIFO
  localparam logic [9:0] MASK_DEFAULT = 10'h07F;   // Default FIFO size residual mask
  localparam logic [9:0] MASK_EXTENDED = 10'h3FF;  // Extended FIFO size residual mask
  localparam logic [31:0] PTR_STEP = 32'h0000_0004; // Pointer advance per fetched word
  localparam logic [31:0] PTR_RESET = 32'h0000_0000;
  localparam logic [23:0] COUNT_RESET = 24'h00_0000;
  localparam logic [9:0] OFFSET_RESET = 10'h000;
  localparam logic [4:0] SFIFO_RESET = 5'h00;
  localparam logic [7:0] CMD_RESET = 8'h00;

  // ********************************************************************
  // Status and control bit positions
  // ********************************************************************
  localparam int BIT_ODL = 5;      // Output data latch full (first/third status)
  localparam int BIT_ODR = 6;      // Output holding register full (first/third status)
  localparam int BIT_IDL = 7;      // Input data latch full (first/third status)
  localparam int BIT_SF_EXT = 4;   // Receive FIFO count extension (third status)
  localparam int BIT_WIDE_RX = 0;  // Wide receive flag (second control)
  localparam int BIT_WIDE_TX = 3;  // Wide send flag (second control)

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,  // Normal transfer
    ST_DRAIN = 2'b01,  // Receive path pushed into the DMA FIFO
    ST_FLUSH = 2'b10,  // DMA FIFO written out to host memory
    ST_HOLD  = 2'b11   // Frozen for software recovery
  } srbr_state_e;

  // Per-latch set/clear events, index 0 = low byte, 1 = high byte
  typedef struct packed {
    logic [1:0] odl_set;
    logic [1:0] odl_clr;
    logic [1:0] odr_set;
    logic [1:0] odr_clr;
    logic [1:0] idl_set;
    logic [1:0] idl_clr;
  } srbr_lat_ev_s;

  // Latch-full flags held by the block
  typedef struct packed {
    logic [1:0] odl;
    logic [1:0] odr;
    logic [1:0] idl;
    logic wide_rx;
    logic wide_tx;
  } srbr_flags_s;

endpackage

// ==== verilog/srbr_core.sv ====
// Residue tracking for the data path of an instruction-driven SCSI processor.
// Assumes datapath events arrive as one-cycle pulses on CLOCK; the bus phase lines come from pins.
`timescale 1ns/10ps

// Function
// RL1: Pointer advances during fetch, points past instruction.
// RL2: Software subtracts 8 or 12 from pointer.
// RL3: Default size: 7-bit offset, residual masked 0x7F.
// RL4: Extended size: 10-bit offset split, masked 0x3FF.
// RL5: Status bit 5 flags output latch bytes.
// RL6: Odd chained wide move leaves latch byte.
// RL7: Status bit 6 flags output holding bytes.
// RL8: Status bit 7 flags input latch bytes.
// RL9: Control bit 0 flags wide residue byte.
// RL10: Report receive FIFO count, bit 4 extends.
// RL11: Flush bit writes DMA FIFO to memory.
// RL12: Clear bit discards DMA FIFO contents.
// RL13: SCSI clear empties receive FIFO and latches.
// RL14: Phase mismatch stops transfer, raises interrupt.
// RL15: Receive mismatch drains path, wide residue stays.
// RL16: Non-wide action clears wide flags.
// RL17: Software flushes receive only, discards send.
// RL18: Software reads wide flags before other transfers.
// RL19: Software rewrites count and address afterwards.
// RL20: Counters and flags frozen until flush/clear.
module srbr_core (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic PTR_LOAD,                      // Software writes the pointer
  input wire logic [31:0] PTR_DATA,
  input wire logic FETCH_WORD,                    // One instruction word fetched
  input wire logic CMD_LOAD,                      // First word of an instruction fetched
  input wire logic [7:0] CMD_DATA,
  input wire logic COUNT_LOAD,                    // Byte count of a new move loaded
  input wire logic [23:0] COUNT_DATA,
  input wire logic EXT_FIFO,                      // Extended DMA FIFO size selected
  input wire logic DMA_FIFO_OFFSET_PUSH,                    // Byte enters the DMA FIFO
  input wire logic DMA_FIFO_OFFSET_POP,                     // Byte leaves the DMA FIFO
  input wire srbr_pkg::srbr_lat_ev_s LATCH_EV,
  input wire logic CHAIN_ODD_END,                 // Chained wide move ended on an odd count
  input wire logic WIDE_RX_SET,                   // Byte parked in the wide residue latch
  input wire logic NARROW_XFER,                   // Any non-wide send or receive action
  input wire logic SFIFO_PUSH,
  input wire logic SFIFO_POP,
  input wire logic XFER_ACTIVE,                   // A transfer instruction is running
  input wire logic XFER_RECEIVE,                  // Running transfer is a receive
  input wire logic [2:0] EXPECT_PHASE,
  input wire logic [2:0] TARGET_PHASE,            // Phase lines from the bus pins
  input wire logic FLUSH_SET,                     // Flush bit of test_ctl_three written
  input wire logic DCLEAR_SET,                    // DMA FIFO clear bit of test_ctl_three written
  input wire logic SCLEAR_SET,                    // SCSI FIFO clear bit of scsi_test_three written
  output logic [31:0] INSTR_PTR,
  output logic [7:0] INSTR_COMMAND,
  output logic [23:0] BYTE_COUNTER,
  output logic [7:0] DMA_FIFO_OFFSET,
  output logic [1:0] TEST_CTL_FIVE,
  output logic [9:0] RESIDUAL,
  output logic [7:0] SCSI_STATUS_FIRST,
  output logic [7:0] SCSI_STATUS_SECOND,
  output logic [7:0] SCSI_STATUS_THIRD,
  output logic [7:0] SCSI_CTL_SECOND,
  output logic MEM_WRITE,                         // One DMA FIFO byte written to memory
  output logic XFER_HALT,
  output logic PM_IRQ
);

  // ********************************************************************
  // Declarations
  // ********************************************************************
  logic [2:0] phase_meta_ff;       // First synchroniser stage
  logic [2:0] phase_sync_ff;       // Second synchroniser stage
  logic [31:0] ptr_ff;
  logic [31:0] nxt_ptr;
  logic [7:0] cmd_ff;
  logic [7:0] nxt_cmd;
  logic [23:0] count_ff;           // Counts down as bytes enter the FIFO
  logic [23:0] nxt_count;
  logic [9:0] offset_ff;           // Counts down as bytes leave the FIFO
  logic [9:0] nxt_offset;
  logic [4:0] sfifo_ff;
  logic [4:0] nxt_sfifo;
  srbr_pkg::srbr_flags_s flags_ff;
  srbr_pkg::srbr_flags_s nxt_flags;
  srbr_pkg::srbr_state_e state_ff;
  srbr_pkg::srbr_state_e nxt_state;
  logic irq_ff;
  logic nxt_irq;
  logic mem_wr_ff;
  logic nxt_mem_wr;
  logic [9:0] resid_ff;
  logic [9:0] nxt_resid;
  logic [7:0] st1_ff;
  logic [7:0] st2_ff;
  logic [7:0] st3_ff;
  logic [7:0] ctl2_ff;
  logic [7:0] nxt_st1;
  logic [7:0] nxt_st2;
  logic [7:0] nxt_st3;
  logic [7:0] nxt_ctl2;
  logic halt_ff;                   // Registered image of the halted state
  logic nxt_halt;
  logic frozen;                    // Datapath events ignored while recovering
  logic mismatch;
  logic [9:0] resid_now;

  // Residual of the DMA FIFO under the selected size
  function automatic logic [9:0] resid_calc(input logic [9:0] off, input logic [23:0] cnt, input logic ext);
    logic [9:0] diff;
    diff = off - cnt[9:0];
    resid_calc = ext ? (diff & srbr_pkg::MASK_EXTENDED) : (diff & srbr_pkg::MASK_DEFAULT); // [RL3] [RL4]
  endfunction

  // ********************************************************************
  // Phase pin synchroniser
  // ********************************************************************
  // Two stages before the comparator; the first stage feeds nothing else
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      phase_meta_ff <= 3'h0;
      phase_sync_ff <= 3'h0;
    end else begin
      phase_meta_ff <= TARGET_PHASE;
      phase_sync_ff <= phase_meta_ff;
    end
  end

  assign frozen = (state_ff != srbr_pkg::ST_RUN);
  assign mismatch = XFER_ACTIVE && (phase_sync_ff != EXPECT_PHASE); // [RL14]
  assign resid_now = resid_calc(offset_ff, count_ff, EXT_FIFO);

  // ********************************************************************
  // Instruction pointer and command
  // ********************************************************************
  // Advancing on each fetched word leaves the pointer past the running instruction
  always_comb begin
    nxt_ptr = ptr_ff;
    nxt_cmd = cmd_ff;
    if (PTR_LOAD) begin
      nxt_ptr = PTR_DATA;
    end else if (FETCH_WORD) begin
      nxt_ptr = ptr_ff + srbr_pkg::PTR_STEP; // [RL1]
    end
    if (CMD_LOAD) begin
      nxt_cmd = CMD_DATA; // Lets software pick 8 or 12 back [RL2]
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ptr_ff <= srbr_pkg::PTR_RESET;
      cmd_ff <= srbr_pkg::CMD_RESET;
    end else begin
      ptr_ff <= nxt_ptr;
      cmd_ff <= nxt_cmd;
    end
  end

  // ********************************************************************
  // Recovery sequencer, counters and flags
  // ********************************************************************
  // One process owns every counter so a drain step and a datapath event never collide
  always_comb begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    nxt_offset = offset_ff;
    nxt_sfifo = sfifo_ff;
    nxt_flags = flags_ff;
    nxt_irq = irq_ff;
    nxt_mem_wr = 1'b0;
    case (state_ff)
      srbr_pkg::ST_RUN: begin
        // Normal datapath bookkeeping
        if (COUNT_LOAD) begin
          nxt_count = COUNT_DATA;
          nxt_offset = COUNT_DATA[9:0];   // Empty FIFO: residual starts at zero
        end else begin
          if (DMA_FIFO_OFFSET_PUSH) begin
            nxt_count = count_ff - 24'h00_0001;
          end
          if (DMA_FIFO_OFFSET_POP) begin
            nxt_offset = offset_ff - 10'h001;
          end
        end
        if (SFIFO_PUSH && !SFIFO_POP) begin
          nxt_sfifo = sfifo_ff + 5'h01; // [RL10]
        end else if (SFIFO_POP && !SFIFO_PUSH && sfifo_ff != 5'h00) begin
          nxt_sfifo = sfifo_ff - 5'h01; // [RL10]
        end
        // Clear first, then set, so a same-cycle set wins
        nxt_flags.odl = (flags_ff.odl & ~LATCH_EV.odl_clr) | LATCH_EV.odl_set; // [RL5]
        nxt_flags.odr = (flags_ff.odr & ~LATCH_EV.odr_clr) | LATCH_EV.odr_set; // [RL7]
        nxt_flags.idl = (flags_ff.idl & ~LATCH_EV.idl_clr) | LATCH_EV.idl_set; // [RL8]
        // Narrow clear goes before both wide sets, so a same-cycle set wins
        if (NARROW_XFER) begin
          nxt_flags.wide_tx = 1'b0;     // [RL16]
          nxt_flags.wide_rx = 1'b0;     // [RL16]
        end
        if (CHAIN_ODD_END) begin
          nxt_flags.odl[0] = 1'b1;      // Odd byte stays in the output latch [RL6]
          nxt_flags.wide_tx = 1'b1;     // [RL6]
        end
        if (WIDE_RX_SET) begin
          nxt_flags.wide_rx = 1'b1;     // [RL9]
        end
        if (mismatch) begin
          nxt_irq = 1'b1; // [RL14]
          nxt_state = XFER_RECEIVE ? srbr_pkg::ST_DRAIN : srbr_pkg::ST_HOLD; // [RL15]
        end
      end
      srbr_pkg::ST_DRAIN: begin
        // One byte per cycle from the receive FIFO, then the input latches
        if (sfifo_ff != 5'h00) begin
          nxt_sfifo = sfifo_ff - 5'h01; // [RL15]
          nxt_count = count_ff - 24'h00_0001;
        end else if (flags_ff.idl[0]) begin
          nxt_flags.idl[0] = 1'b0; // [RL15]
          nxt_count = count_ff - 24'h00_0001;
        end else if (flags_ff.idl[1]) begin
          nxt_flags.idl[1] = 1'b0; // [RL15]
          nxt_count = count_ff - 24'h00_0001;
        end else begin
          nxt_state = srbr_pkg::ST_FLUSH;
        end
      end
      srbr_pkg::ST_FLUSH: begin
        // Write each DMA FIFO byte out; wide residue latch is untouched
        if (resid_now != 10'h000) begin
          nxt_offset = offset_ff - 10'h001; // [RL11]
          nxt_mem_wr = 1'b1; // [RL11]
        end else begin
          nxt_state = srbr_pkg::ST_HOLD;
        end
      end
      srbr_pkg::ST_HOLD: begin
        // Values frozen for software; leaves only on flush or clear [RL20]
        if (FLUSH_SET) begin
          nxt_state = srbr_pkg::ST_FLUSH;
          nxt_irq = 1'b0;
        end else if (DCLEAR_SET || SCLEAR_SET) begin
          nxt_state = srbr_pkg::ST_RUN;
          nxt_irq = 1'b0;
        end
      end
      default: begin
        nxt_state = srbr_pkg::ST_HOLD;
      end
    endcase
    // Clear bits act in any state after the step above; the flush bit here acts only in RUN
    if (FLUSH_SET && state_ff == srbr_pkg::ST_RUN) begin
      nxt_state = srbr_pkg::ST_FLUSH; // [RL11]
    end
    if (DCLEAR_SET) begin
      nxt_offset = nxt_count[9:0]; // Discard without memory writes [RL12]
      nxt_mem_wr = 1'b0; // [RL12]
      if (state_ff == srbr_pkg::ST_FLUSH) begin
        nxt_state = srbr_pkg::ST_RUN;
      end
    end
    if (SCLEAR_SET) begin
      nxt_sfifo = srbr_pkg::SFIFO_RESET; // [RL13]
      // In RUN only what an event sets in this same cycle survives; outside RUN every flag clears
      nxt_flags.odl = frozen ? 2'b00 : (LATCH_EV.odl_set | {1'b0, CHAIN_ODD_END}); // [RL13]
      nxt_flags.odr = frozen ? 2'b00 : LATCH_EV.odr_set; // [RL13]
      nxt_flags.idl = frozen ? 2'b00 : LATCH_EV.idl_set; // [RL13]
      nxt_flags.wide_rx = !frozen && WIDE_RX_SET; // [RL13]
      nxt_flags.wide_tx = !frozen && CHAIN_ODD_END;
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_ff <= srbr_pkg::ST_RUN;
      count_ff <= srbr_pkg::COUNT_RESET;
      offset_ff <= srbr_pkg::OFFSET_RESET;
      sfifo_ff <= srbr_pkg::SFIFO_RESET;
      flags_ff <= '0;
      irq_ff <= 1'b0;
      mem_wr_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
      offset_ff <= nxt_offset;
      sfifo_ff <= nxt_sfifo;
      flags_ff <= nxt_flags;
      irq_ff <= nxt_irq;
      mem_wr_ff <= nxt_mem_wr;
    end
  end

  // ********************************************************************
  // Status images
  // ********************************************************************
  // Built from the next values, so status bytes move on the same edge as the counters
  always_comb begin
    nxt_resid = resid_calc(nxt_offset, nxt_count, EXT_FIFO); // [RL3] [RL4]
    nxt_halt = (nxt_state != srbr_pkg::ST_RUN); // Stands until back in RUN [RL14]
    nxt_st1 = 8'h00;
    nxt_st3 = 8'h00;
    nxt_st2 = 8'h00;
    nxt_ctl2 = 8'h00;
    nxt_st1[srbr_pkg::BIT_ODL] = nxt_flags.odl[0]; // [RL5]
    nxt_st3[srbr_pkg::BIT_ODL] = nxt_flags.odl[1]; // [RL5]
    nxt_st1[srbr_pkg::BIT_ODR] = nxt_flags.odr[0]; // [RL7]
    nxt_st3[srbr_pkg::BIT_ODR] = nxt_flags.odr[1]; // [RL7]
    nxt_st1[srbr_pkg::BIT_IDL] = nxt_flags.idl[0]; // [RL8]
    nxt_st3[srbr_pkg::BIT_IDL] = nxt_flags.idl[1]; // [RL8]
    nxt_st2[3:0] = nxt_sfifo[3:0]; // [RL10]
    nxt_st3[srbr_pkg::BIT_SF_EXT] = nxt_sfifo[4]; // [RL10]
    nxt_ctl2[srbr_pkg::BIT_WIDE_RX] = nxt_flags.wide_rx; // [RL9]
    nxt_ctl2[srbr_pkg::BIT_WIDE_TX] = nxt_flags.wide_tx;
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      resid_ff <= srbr_pkg::OFFSET_RESET;
      st1_ff <= 8'h00;
      st2_ff <= 8'h00;
      st3_ff <= 8'h00;
      ctl2_ff <= 8'h00;
      halt_ff <= 1'b0;
    end else begin
      resid_ff <= nxt_resid;
      st1_ff <= nxt_st1;
      st2_ff <= nxt_st2;
      st3_ff <= nxt_st3;
      ctl2_ff <= nxt_ctl2;
      halt_ff <= nxt_halt;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign INSTR_PTR = ptr_ff;
  assign INSTR_COMMAND = cmd_ff;
  assign BYTE_COUNTER = count_ff;
  assign DMA_FIFO_OFFSET = offset_ff[7:0]; // [RL4]
  assign TEST_CTL_FIVE = offset_ff[9:8]; // [RL4]
  assign RESIDUAL = resid_ff;
  assign SCSI_STATUS_FIRST = st1_ff;
  assign SCSI_STATUS_SECOND = st2_ff;
  assign SCSI_STATUS_THIRD = st3_ff;
  assign SCSI_CTL_SECOND = ctl2_ff;
  assign MEM_WRITE = mem_wr_ff;
  assign XFER_HALT = halt_ff; // [RL14]
  assign PM_IRQ = irq_ff;

endmodule

// ==== verification/srbr_target_model.sv ====
// Behavioural bus target that drives the phase lines toward a commanded phase.
// Assumes the bench sets the wanted phase and a lag in core clock cycles.
`timescale 1ns/10ps
module srbr_target_model (
  input wire logic clk,
  input wire logic [2:0] want_phase,
  input wire logic [3:0] lag,
  output logic [2:0] phase
);
  // ****************
  // Phase lines
  // ****************
  // Lines start in the first data phase
  initial phase = 3'h0;
  // Pins move between edges: the target is not clocked by us
  always @(want_phase) begin
    repeat (lag) @(posedge clk);
    #7 phase = want_phase;
  end
endmodule

// ==== verification/srbr_core_props.sv ====
// Checker of port timing for the residue tracking block.
// Assumes status bytes and the residual move on the same edge as the counters and flags.
`timescale 1ns/10ps
module srbr_core_props (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic FETCH_WORD,
  input wire logic PTR_LOAD,
  input wire logic COUNT_LOAD,
  input wire logic EXT_FIFO,
  input wire logic DMA_FIFO_OFFSET_PUSH,
  input wire srbr_pkg::srbr_lat_ev_s LATCH_EV,
  input wire logic CHAIN_ODD_END,
  input wire logic WIDE_RX_SET,
  input wire logic NARROW_XFER,
  input wire logic SFIFO_PUSH,
  input wire logic SFIFO_POP,
  input wire logic XFER_ACTIVE,
  input wire logic XFER_RECEIVE,
  input wire logic [2:0] EXPECT_PHASE,
  input wire logic [2:0] TARGET_PHASE,
  input wire logic FLUSH_SET,
  input wire logic DCLEAR_SET,
  input wire logic SCLEAR_SET,
  input wire logic [31:0] INSTR_PTR,
  input wire logic [23:0] BYTE_COUNTER,
  input wire logic [7:0] DMA_FIFO_OFFSET,
  input wire logic [1:0] TEST_CTL_FIVE,
  input wire logic [9:0] RESIDUAL,
  input wire logic [7:0] SCSI_STATUS_FIRST,
  input wire logic [7:0] SCSI_STATUS_SECOND,
  input wire logic [7:0] SCSI_STATUS_THIRD,
  input wire logic [7:0] SCSI_CTL_SECOND,
  input wire logic MEM_WRITE,
  input wire logic XFER_HALT,
  input wire logic PM_IRQ
);
  // ****************
  // Helpers
  // ****************
  wire run = !XFER_HALT;  // Datapath pulses count only while running
  wire [9:0] off = {TEST_CTL_FIVE, DMA_FIFO_OFFSET};  // Split offset counter
  wire [4:0] sf = {SCSI_STATUS_THIRD[4], SCSI_STATUS_SECOND[3:0]};  // Receive count
  wire [9:0] msk = EXT_FIFO ? srbr_pkg::MASK_EXTENDED : srbr_pkg::MASK_DEFAULT;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // ****************
  // Assertions
  // ****************
  a_ptr_fetch_step: assert property (
    FETCH_WORD && !PTR_LOAD && run |=> INSTR_PTR == $past(INSTR_PTR) + srbr_pkg::PTR_STEP)
    else $error("pointer did not step on fetch");
  a_count_step: assert property (
    DMA_FIFO_OFFSET_PUSH && !COUNT_LOAD && run |=> BYTE_COUNTER == $past(BYTE_COUNTER) - 24'h00_0001)
    else $error("byte counter did not step");
  // Residual is registered with the counters; the mask is last cycle's, hence the stable size
  a_resid_calc: assert property (
    $stable(EXT_FIFO) |-> RESIDUAL == ((off - BYTE_COUNTER[9:0]) & msk))
    else $error("residual differs from offset minus count");
  a_odr_low_flag: assert property (
    LATCH_EV.odr_set[0] && run |=> SCSI_STATUS_FIRST[6]) else $error("holding flag missing");
  a_idl_high_flag: assert property (
    LATCH_EV.idl_set[1] && run |=> SCSI_STATUS_THIRD[7]) else $error("input latch flag missing");
  a_chain_odd_byte: assert property (
    CHAIN_ODD_END && run |=> SCSI_STATUS_FIRST[5] && SCSI_CTL_SECOND[3])
    else $error("odd chained byte not flagged");
  a_wide_rx_set: assert property (
    WIDE_RX_SET && run |=> SCSI_CTL_SECOND[0]) else $error("wide receive flag missing");
  a_narrow_clears: assert property (
    NARROW_XFER && !WIDE_RX_SET && !CHAIN_ODD_END && run |=> SCSI_CTL_SECOND[3:0] == 4'h0)
    else $error("narrow action left a wide flag");
  a_sfifo_count: assert property (
    SFIFO_PUSH && !SFIFO_POP && !SCLEAR_SET && run |=> sf == $past(sf) + 5'h01)
    else $error("receive count did not rise");
  a_pm_raise: assert property (
    (XFER_ACTIVE && run && TARGET_PHASE != EXPECT_PHASE) [*3] |-> ##[0:2] PM_IRQ && XFER_HALT)
    else $error("phase mismatch not reported");
  // Send side only: a receive drains while the interrupt already stands
  a_hold_freeze: assert property (
    (PM_IRQ && !XFER_RECEIVE && !FLUSH_SET && !DCLEAR_SET && !SCLEAR_SET) [*3]
    |-> $stable(BYTE_COUNTER) && $stable(RESIDUAL) && $stable(SCSI_STATUS_FIRST))
    else $error("residue state moved during hold");
  c_pm: cover property ($rose(PM_IRQ));
  c_flush: cover property (MEM_WRITE);
  c_wide: cover property ($rose(SCSI_CTL_SECOND[0]));
endmodule
bind srbr_core srbr_core_props u_props (.*);

// ==== verification/tb.sv ====
// Self-checking bench for the residue tracking block and its bus target.
// Assumes the checker is bound from its own file; inputs move on falling edges.
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ptr_ld = 1'b0, fetch = 1'b0, cmd_ld = 1'b0, cnt_ld = 1'b0, ext = 1'b0, push = 1'b0;
  logic pop = 1'b0, chain = 1'b0, wrx = 1'b0, narrow = 1'b0, spush = 1'b0, spop = 1'b0;
  logic act = 1'b0, recv = 1'b0, fl = 1'b0, dclr = 1'b0, sclr = 1'b0;
  logic [31:0] ptr_d = 32'h0000_1000;
  logic [7:0] cmd_d = 8'hC0;
  logic [23:0] cnt_d = 24'h00_0000;
  logic [2:0] want = 3'h0;
  logic [2:0] expph = 3'h0;  // Phase the running move expects
  logic [3:0] lag = 4'h0;
  srbr_pkg::srbr_lat_ev_s lev = '0;
  wire [2:0] tph;
  logic [31:0] iptr;
  logic [23:0] bcnt;
  logic [9:0] resid;
  logic [7:0] icmd, dfo, st1, st2, st3, ctl2;
  logic [1:0] tc5;
  logic mw, halt, irq;
  int failures = 0;
  int samples_checked = 0;
  int mw_n = 0;  // Memory writes seen
  always #12.5 clk = ~clk;
  always @(posedge clk) if (mw === 1'b1) mw_n++;
  srbr_target_model u_tgt (.clk(clk), .want_phase(want), .lag(lag), .phase(tph));
  srbr_core u_dut (.CLOCK(clk), .SYS_RST(rst), .PTR_LOAD(ptr_ld), .PTR_DATA(ptr_d),
    .FETCH_WORD(fetch), .CMD_LOAD(cmd_ld), .CMD_DATA(cmd_d), .COUNT_LOAD(cnt_ld),
    .COUNT_DATA(cnt_d), .EXT_FIFO(ext), .DMA_FIFO_OFFSET_PUSH(push), .DMA_FIFO_OFFSET_POP(pop), .LATCH_EV(lev),
    .CHAIN_ODD_END(chain), .WIDE_RX_SET(wrx), .NARROW_XFER(narrow), .SFIFO_PUSH(spush),
    .SFIFO_POP(spop), .XFER_ACTIVE(act), .XFER_RECEIVE(recv), .EXPECT_PHASE(expph),
    .TARGET_PHASE(tph), .FLUSH_SET(fl), .DCLEAR_SET(dclr), .SCLEAR_SET(sclr),
    .INSTR_PTR(iptr), .INSTR_COMMAND(icmd), .BYTE_COUNTER(bcnt), .DMA_FIFO_OFFSET(dfo),
    .TEST_CTL_FIVE(tc5), .RESIDUAL(resid), .SCSI_STATUS_FIRST(st1), .SCSI_STATUS_SECOND(st2),
    .SCSI_STATUS_THIRD(st3), .SCSI_CTL_SECOND(ctl2), .MEM_WRITE(mw), .XFER_HALT(halt),
    .PM_IRQ(irq));
  // ****************
  // Shared tasks
  // ****************
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // High for n cycles gives n back-to-back pulses
  task automatic pulse(ref logic s, input int n);
    s = 1'b1;
    tick(n);
    s = 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait; the caller judges the flag afterwards
  task automatic wait_irq;
    for (int i = 0; i < 20; i++) if (irq !== 1'b1) tick(1);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_ptr;
    ptr_ld = 1'b1;
    cmd_ld = 1'b1;
    tick(1);
    ptr_ld = 1'b0;
    cmd_ld = 1'b0;
    pulse(fetch, 2);
    tick(1);
    chk(iptr, 32'h0000_1008);
    chk(icmd, 32'h0000_00C0);
    $display("test ptr done");
  endtask
  // 130 bytes overflow the default mask but not the extended one
  task automatic t_resid(input logic e);
    ext = e;
    cnt_d = 24'h00_0300;
    pulse(cnt_ld, 1);
    pulse(push, 130);
    pulse(pop, 1);
    tick(2);
    chk(bcnt, 24'h00_0300 - 130);
    chk({tc5, dfo}, 10'h2FF);
    chk(resid, 129 & (e ? 10'h3FF : 10'h07F));
    $display("test residual done");
  endtask
  task automatic t_flags;
    for (int i = 0; i < 6; i++) begin
      for (int k = 0; k < 2; k++) begin
        lev[10 - 4 * (i / 2) + i % 2 - 2 * k] = 1'b1;
        tick(1);
        lev = '0;
        tick(2);
        chk(i % 2 ? st3[5 + i / 2] : st1[5 + i / 2], 1 - k);
      end
    end
    pulse(chain, 1);
    tick(2);
    chk({st1[5], ctl2[3]}, 2'h3);
    pulse(wrx, 1);
    tick(2);
    chk(ctl2[0], 1'b1);
    pulse(narrow, 1);
    tick(2);
    chk({ctl2[3], ctl2[0]}, 2'h0);
    pulse(spush, 17);
    tick(2);
    chk({st3[4], st2[3:0]}, 5'h11);
    pulse(spop, 15);
    tick(2);
    chk({st3[4], st2[3:0]}, 5'h02);
    $display("test flags done");
  endtask
  // Slow target first agrees with the expected phase, then leaves a send; pushes in hold are ignored
  task automatic t_send;
    cnt_d = 24'h00_0040;
    pulse(cnt_ld, 1);
    pulse(push, 3);
    expph = 3'h5;
    lag = 4'h3;
    want = 3'h5;
    tick(8);
    act = 1'b1;
    tick(4);
    chk({irq, halt}, 2'h0);
    want = 3'h2;
    wait_irq;
    chk({irq, halt}, 2'h3);
    pulse(push, 2);
    tick(3);
    chk(bcnt, 24'h00_003D);
    chk({resid, st1[5]}, {10'h003, 1'b1});
    act = 1'b0;
    want = 3'h0;
    expph = 3'h0;
    mw_n = 0;
    tick(8);
    pulse(dclr, 1);
    tick(2);
    chk({irq, halt, resid}, 12'h000);
    chk(mw_n, 0);
    $display("test send done");
  endtask
  // Prompt target leaves a receive with two FIFO bytes, one latch byte, one wide byte
  task automatic t_recv;
    recv = 1'b1;
    cnt_d = 24'h00_0064;
    pulse(cnt_ld, 1);
    pulse(push, 4);
    lev.idl_set[0] = 1'b1;
    wrx = 1'b1;
    tick(1);
    lev = '0;
    wrx = 1'b0;
    mw_n = 0;
    act = 1'b1;
    lag = 4'h0;
    want = 3'h1;
    wait_irq;
    tick(40);
    chk(mw_n, 7);
    chk(bcnt, 24'h00_005D);
    chk({st1[7], st3[7], st3[4], st2[3:0], resid}, 17'h0_0000);
    chk(ctl2[0], 1'b1);
    act = 1'b0;
    want = 3'h0;
    tick(4);
    pulse(sclr, 1);
    tick(2);
    chk({irq, ctl2[0], st1[5]}, 3'h0);
    recv = 1'b0;
    // Software rewrites the remaining count, then flushes a fresh residue itself
    cnt_d = 24'h00_0040;
    pulse(cnt_ld, 1);
    tick(1);
    chk(bcnt, 24'h00_0040);
    pulse(push, 3);
    mw_n = 0;
    pulse(fl, 1);
    tick(8);
    chk(mw_n, 3);
    chk({halt, resid}, 11'h400);
    pulse(dclr, 1);
    tick(2);
    chk(halt, 1'b0);
    $display("test receive done");
  endtask
  // ****************
  // Verdict
  // ****************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    tick(2);
    t_ptr;
    t_resid(1'b0);
    t_resid(1'b1);
    t_flags;
    t_send;
    t_recv;
    finish_test;
  end
  // Whole run is near five hundred cycles; this margin only catches a hang
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test;
  end
endmodule
